// ==== verilog/mccs_defines.vh ====
// Purpose: Offsets, field positions, reset values and codes for the
//          channel configuration and status register group.
// Assumes: 16-bit register addresses on the host register port.
// Notes:   Definitions only; included by the register group design file alone.
`ifndef MCCS_DEFINES_VH
`define MCCS_DEFINES_VH

// ==========================================================
// Register offsets
`define MCCS_OFS_HPF_DISABLE 16'h4389
`define MCCS_OFS_CUR_PEAK 16'hE500
`define MCCS_OFS_VOLT_PEAK 16'hE501
`define MCCS_OFS_OVC_STATUS 16'hE600
`define MCCS_OFS_NOLOAD 16'hE608
`define MCCS_OFS_COMP_MODE 16'hE60E
`define MCCS_OFS_GAIN 16'hE60F

// ==========================================================
// Reset values
`define MCCS_RST_HPF_DISABLE 24'h000000
`define MCCS_RST_COMP_MODE 16'h01FF
`define MCCS_RST_GAIN 16'h0000

// ==========================================================
// Field positions
`define MCCS_PEAK_MAG_MSB 23
`define MCCS_PEAK_SRC_LSB 24
`define MCCS_OVC_SRC_LSB 3
`define MCCS_CM_BANK_BIT 14
`define MCCS_CM_ANGLE_MSB 10
`define MCCS_CM_ANGLE_LSB 9
`define MCCS_CM_LOW_MSB 8
`define MCCS_GAIN_DEF_LSB 6
`define MCCS_GAIN_VOLT_LSB 3
`define MCCS_GAIN_ABC_LSB 0

// ==========================================================
// Angle select codes
`define MCCS_ANGLE_DELAY 2'h0
`define MCCS_ANGLE_RSVD 2'h1
`define MCCS_ANGLE_CURRENT 2'h2
`define MCCS_ANGLE_NONE 2'h3

`endif

// ==== verilog/mccs_peak_pick.v ====
// Purpose: Pick the largest enabled magnitude among three bank channels.
// Assumes: Magnitudes are unsigned; enables come from measurement mode.
// Notes:   Purely combinational; ties go to the lowest channel.
`timescale 1ns/1ps

module mccs_peak_pick #(
  parameter WIDTH = 24
) (
  input wire [3*WIDTH-1:0] i_mag,
  input wire [2:0] i_enable,
  output reg [WIDTH-1:0] o_max,
  output reg [2:0] o_src
);

  wire [WIDTH-1:0] masked [0:2];

  // ==========================================================
  // Masking
  // Disabled channels look like zero so they never win
  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1) begin : g_mask
      assign masked[g] = i_enable[g] ? i_mag[g*WIDTH +: WIDTH] : {WIDTH{1'b0}};
    end
  endgenerate

  // ==========================================================
  // Maximum search
  // Source stays zero when no channel is enabled
  always @* begin
    o_max = masked[0];
    o_src = {2'b00, i_enable[0]};
    if (masked[1] > o_max) begin
      o_max = masked[1];
      o_src = 3'h2;
    end
    if (masked[2] > o_max) begin
      o_max = masked[2];
      o_src = 3'h4;
    end
  end

endmodule // mccs_peak_pick

// ==== verilog/mccs_regs.v ====
// Purpose: Configuration and status register group of a six-current,
//          one-voltage channel metering core.
// Assumes: Host serial port logic presents decoded word accesses;
//          measurement logic supplies samples and event pulses.
// Notes:   Read data is registered, one cycle after the read strobe.
//
// Notes on behaviour
// - Zero disable word keeps filters active
// - Any nonzero disable word bypasses all filters
// - Current peak magnitude in low 24 bits
// - One source flag bit 24..26 per channel
// - Voltage peak in low 24, upper zero
// - Overcurrent source flags at bits 3..5
// - Overcurrent status bits 2..0 read zero
// - One no-load bit per channel A..F
// - Bank bit clear selects channels A, B, C
// - Bank bit set selects channels D, E, F
// - Angle code 00 measures voltage-current delays
// - Code 10 measures current angles; 01 reserved
// - Code 11 disables all angle measurement
// - Gain bits 8..6 set D, E, F gain
// - Gain bits 5..3 set voltage gain
// - Gain bits 2..0 set A, B, C gain
// - Peak uses only enabled channels of bank
`timescale 1ns/1ps
`include "mccs_defines.vh"

module mccs_regs #(
  parameter MAG_W = 24
) (
  input wire i_clock,
  input wire i_resetn,
  // Host register port
  input wire i_reg_wr,
  input wire i_reg_rd,
  input wire [15:0] i_reg_addr,
  input wire [31:0] i_reg_wdata,
  output reg [31:0] o_reg_rdata,
  output reg o_reg_rvalid,
  // Measurement side
  input wire [6*MAG_W-1:0] i_cur_mag,
  input wire i_cur_valid,
  input wire [MAG_W-1:0] i_volt_mag,
  input wire i_volt_valid,
  input wire i_peak_restart,
  input wire [2:0] i_peak_enable,
  input wire [2:0] i_overcurrent_evt,
  input wire i_overcurrent_clear,
  input wire [5:0] i_noload,
  // Configuration outputs
  output wire o_hpf_bypass,
  output wire o_bank_def_sel,
  output wire o_delay_meas_en,
  output wire o_angle_cur_en,
  output wire [2:0] o_gain_abc,
  output wire [2:0] o_gain_voltage,
  output wire [2:0] o_gain_def,
  output wire [3*MAG_W-1:0] o_bank_cur_mag
);

  // ==========================================================
  // Storage
  reg [23:0] hpf_disable_ff;
  reg [15:0] comp_mode_ff;
  reg [15:0] gain_ff;
  reg [MAG_W-1:0] cur_peak_ff;
  reg [2:0] cur_src_ff;
  reg [MAG_W-1:0] volt_peak_ff;
  reg [2:0] ovc_src_ff;
  reg [5:0] noload_ff;
  reg [31:0] nxt_rdata;
  reg [MAG_W-1:0] nxt_cur_peak;
  reg [2:0] nxt_cur_src;
  reg [MAG_W-1:0] nxt_volt_peak;
  reg [2:0] nxt_ovc_src;
  wire [MAG_W-1:0] pick_max;
  wire [2:0] pick_src;
  wire [1:0] angle_sel;

  // ==========================================================
  // Configuration decode
  // Filters stay in circuit only for an all-zero disable word
  assign o_hpf_bypass = |hpf_disable_ff;
  assign o_bank_def_sel = comp_mode_ff[`MCCS_CM_BANK_BIT];
  assign angle_sel = comp_mode_ff[`MCCS_CM_ANGLE_MSB:`MCCS_CM_ANGLE_LSB];
  assign o_delay_meas_en = (angle_sel == `MCCS_ANGLE_DELAY);
  // Reserved code 01 is treated like 11: nothing is measured
  assign o_angle_cur_en = (angle_sel == `MCCS_ANGLE_CURRENT);
  assign o_gain_def = gain_ff[`MCCS_GAIN_DEF_LSB +: 3];
  assign o_gain_voltage = gain_ff[`MCCS_GAIN_VOLT_LSB +: 3];
  assign o_gain_abc = gain_ff[`MCCS_GAIN_ABC_LSB +: 3];

  // Bank steering for peak, overcurrent, zero crossing, angle, waveform
  assign o_bank_cur_mag = o_bank_def_sel ? i_cur_mag[6*MAG_W-1:3*MAG_W] : i_cur_mag[3*MAG_W-1:0];

  // ==========================================================
  // Peak selection among the active bank
  mccs_peak_pick #(
    .WIDTH(MAG_W)
  ) u_pick (
    .i_mag(o_bank_cur_mag),
    .i_enable(i_peak_enable),
    .o_max(pick_max),
    .o_src(pick_src)
  );

  // ==========================================================
  // Next values of measurement-owned registers
  // Restart wins: a new capture period begins from zero, and a sample
  // arriving with the restart is dropped to keep periods disjoint.
  always @* begin
    nxt_cur_peak = cur_peak_ff;
    nxt_cur_src = cur_src_ff;
    nxt_volt_peak = volt_peak_ff;
    nxt_ovc_src = ovc_src_ff;
    if (i_peak_restart) begin
      nxt_cur_peak = {MAG_W{1'b0}};
      nxt_cur_src = 3'h0;
      nxt_volt_peak = {MAG_W{1'b0}};
    end else begin
      if (i_cur_valid && (pick_max > cur_peak_ff)) begin
        nxt_cur_peak = pick_max;
        nxt_cur_src = pick_src;
      end
      if (i_volt_valid && (i_volt_mag > volt_peak_ff)) begin
        nxt_volt_peak = i_volt_mag;
      end
    end
    // A new event beats a clear in the same cycle
    if (|i_overcurrent_evt) begin
      nxt_ovc_src = i_overcurrent_evt;
    end else if (i_overcurrent_clear) begin
      nxt_ovc_src = 3'h0;
    end
  end

  // Status registers follow the measurement logic only
  always @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      cur_peak_ff <= {MAG_W{1'b0}};
      cur_src_ff <= 3'h0;
      volt_peak_ff <= {MAG_W{1'b0}};
      ovc_src_ff <= 3'h0;
      noload_ff <= 6'h00;
    end else begin
      cur_peak_ff <= nxt_cur_peak;
      cur_src_ff <= nxt_cur_src;
      volt_peak_ff <= nxt_volt_peak;
      ovc_src_ff <= nxt_ovc_src;
      noload_ff <= i_noload;
    end
  end

  // ==========================================================
  // Host writes to configuration registers
  // Reserved bits are not stored so they always read back as zero;
  // low mode bits are stored as written, software must keep them.
  always @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      hpf_disable_ff <= `MCCS_RST_HPF_DISABLE;
      comp_mode_ff <= `MCCS_RST_COMP_MODE;
      gain_ff <= `MCCS_RST_GAIN;
    end else if (i_reg_wr) begin
      case (i_reg_addr)
        `MCCS_OFS_HPF_DISABLE: begin
          hpf_disable_ff <= i_reg_wdata[23:0];
        end
        `MCCS_OFS_COMP_MODE: begin
          comp_mode_ff <= {1'b0, i_reg_wdata[14], 3'h0, i_reg_wdata[10:0]};
        end
        `MCCS_OFS_GAIN: begin
          gain_ff <= {7'h00, i_reg_wdata[8:0]};
        end
        default: begin
          // Status and unmapped offsets ignore writes
          gain_ff <= gain_ff;
        end
      endcase
    end
  end

  // ==========================================================
  // Read multiplexer
  always @* begin
    case (i_reg_addr)
      `MCCS_OFS_HPF_DISABLE: nxt_rdata = {8'h00, hpf_disable_ff};
      `MCCS_OFS_CUR_PEAK: nxt_rdata = {5'h00, cur_src_ff, cur_peak_ff};
      `MCCS_OFS_VOLT_PEAK: nxt_rdata = {8'h00, volt_peak_ff};
      `MCCS_OFS_OVC_STATUS: nxt_rdata = {26'h0000000, ovc_src_ff, 3'h0};
      `MCCS_OFS_NOLOAD: nxt_rdata = {26'h0000000, noload_ff};
      `MCCS_OFS_COMP_MODE: nxt_rdata = {16'h0000, comp_mode_ff};
      `MCCS_OFS_GAIN: nxt_rdata = {16'h0000, gain_ff};
      default: nxt_rdata = 32'h00000000;
    endcase
  end

  // Registered read answer, one cycle after the strobe
  always @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      o_reg_rdata <= 32'h00000000;
      o_reg_rvalid <= 1'b0;
    end else begin
      o_reg_rvalid <= i_reg_rd;
      if (i_reg_rd) begin
        o_reg_rdata <= nxt_rdata;
      end
    end
  end

endmodule // mccs_regs

// ==== testbench/mccs_regs_asserts.sv ====
// Purpose: Port-level checks for the register group.
// Assumes: One clock, asynchronous active-low reset.
// Notes:   Bound into every mccs_regs instance.
`timescale 1ns/1ps
// ==========================================
// Checker
module mccs_regs_asserts (
  input wire i_clock,
  input wire i_resetn,
  input wire i_reg_wr,
  input wire i_reg_rd,
  input wire [15:0] i_reg_addr,
  input wire [31:0] i_reg_wdata,
  input wire [31:0] o_reg_rdata,
  input wire o_hpf_bypass,
  input wire o_bank_def_sel,
  input wire o_delay_meas_en,
  input wire o_angle_cur_en,
  input wire [2:0] o_gain_abc,
  input wire [2:0] o_gain_voltage,
  input wire [2:0] o_gain_def
);
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_resetn);
  // Host write cycles, one per register of interest
  sequence hpf_wr; i_reg_wr && i_reg_addr == 16'h4389; endsequence
  sequence mode_wr; i_reg_wr && i_reg_addr == 16'hE60E; endsequence
  sequence gain_wr; i_reg_wr && i_reg_addr == 16'hE60F; endsequence
  bypass_set_a: assert property (hpf_wr ##0 i_reg_wdata[23:0] != 24'h0 |=> o_hpf_bypass)
    else $error("bypass not set");
  bypass_clear_a: assert property (hpf_wr ##0 i_reg_wdata[23:0] == 24'h0 |=> !o_hpf_bypass)
    else $error("bypass not cleared");
  bank_select_a: assert property (mode_wr |=> o_bank_def_sel == $past(i_reg_wdata[14]))
    else $error("bank select wrong");
  delay_code_a: assert property (mode_wr ##0 i_reg_wdata[10:9] == 2'h0 |=> o_delay_meas_en && !o_angle_cur_en)
    else $error("delay mode wrong");
  current_code_a: assert property (mode_wr ##0 i_reg_wdata[10:9] == 2'h2 |=> o_angle_cur_en && !o_delay_meas_en)
    else $error("angle mode wrong");
  no_angle_a: assert property (mode_wr ##0 i_reg_wdata[10:9] == 2'h3 |=> !o_angle_cur_en && !o_delay_meas_en)
    else $error("angle not off");
  gain_fields_a: assert property (gain_wr |=> {o_gain_def, o_gain_voltage, o_gain_abc} == $past(i_reg_wdata[8:0]))
    else $error("gain fields wrong");
  ovc_low_zero_a: assert property (i_reg_rd && i_reg_addr == 16'hE600 |=> o_reg_rdata[2:0] == 3'h0)
    else $error("status low bits set");
endmodule // mccs_regs_asserts

bind mccs_regs mccs_regs_asserts chk (.*);

// ==== testbench/testbench.sv ====
// Purpose: Self-checking bench for the register group.
// Assumes: 10 MHz clock; inputs change 1 ns after the rising edge.
// Notes:   Expected values come from the register layout.
`timescale 1ns/1ps
module testbench;
  reg i_clock = 0, i_resetn = 0, i_reg_wr = 0, i_reg_rd = 0, i_cur_valid = 0, i_volt_valid = 0;
  reg i_peak_restart = 0, i_overcurrent_clear = 0;
  reg [15:0] i_reg_addr = 16'h0;
  reg [31:0] i_reg_wdata = 32'h0;
  reg [143:0] i_cur_mag = 144'h0;
  reg [23:0] i_volt_mag = 24'h0;
  reg [2:0] i_peak_enable = 3'h7, i_overcurrent_evt = 3'h0;
  reg [5:0] i_noload = 6'h0;
  wire [31:0] o_reg_rdata;
  wire o_reg_rvalid, o_hpf_bypass, o_bank_def_sel, o_delay_meas_en, o_angle_cur_en;
  wire [2:0] o_gain_abc, o_gain_voltage, o_gain_def;
  wire [71:0] o_bank_cur_mag;
  integer mismatches = 0, cmp_count = 0, k;
  mccs_regs dut (.*);
  // ==========================================
  // Clock and helpers
  always #50 i_clock = ~i_clock;
  // Config outputs packed so one compare covers them all
  function [31:0] cfg;
    cfg = {16'h0, o_bank_def_sel, o_delay_meas_en, o_angle_cur_en, o_hpf_bypass, 3'h0,
           o_gain_def, o_gain_voltage, o_gain_abc};
  endfunction
  task chk(input [31:0] got, input [31:0] exp); begin
    cmp_count = cmp_count + 1;
    if (got !== exp) begin
      mismatches = mismatches + 1;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  end endtask
  task tick; begin
    @(posedge i_clock);
    #1;
  end endtask
  // Strobes drop with an idle cycle after, so no signal is driven twice in one step
  task wr(input [15:0] a, input [31:0] d); begin
    i_reg_wr = 1;
    i_reg_addr = a;
    i_reg_wdata = d;
    tick;
    i_reg_wr = 0;
    tick;
  end endtask
  task rd(input [15:0] a, input [31:0] e); begin
    i_reg_rd = 1;
    i_reg_addr = a;
    tick;
    chk({31'h0, o_reg_rvalid}, 32'h1);
    chk(o_reg_rdata, e);
    i_reg_rd = 0;
    tick;
  end endtask
  task wrap_up; begin
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  end endtask
  // ==========================================
  // Tests
  initial begin
    tick;
    tick;
    i_resetn = 1;
    rd(16'h4389, 32'h0);
    chk(cfg(), 32'h4000);
    rd(16'hE60E, 32'h1FF);
    rd(16'h1234, 32'h0);
    wr(16'h4389, 32'h800000);
    chk(cfg(), 32'h5000);
    rd(16'h4389, 32'h800000);
    wr(16'h4389, 32'h0);
    chk(cfg(), 32'h4000);
    wr(16'hE60F, 32'hFF24);
    rd(16'hE60F, 32'h124);
    wr(16'hE60F, 32'h0D1);
    chk(cfg(), 32'h40D1);
    // Every bank and angle code; A..F magnitudes are 1..6
    i_cur_mag = {24'h6, 24'h5, 24'h4, 24'h3, 24'h2, 24'h1};
    for (k = 0; k < 8; k = k + 1) begin
      wr(16'hE60E, {16'h0, 1'b0, k[2], 3'h0, k[1:0], 9'h1FF});
      chk(cfg(), {16'h0, k[2], k[1:0] == 2'h0, k[1:0] == 2'h2, 4'h0, 9'h0D1});
      chk({8'h0, o_bank_cur_mag[23:0]}, k[2] ? 32'h4 : 32'h1);
    end
    wr(16'hE60E, 32'h1FF);
    // Peaks: B is largest of bank A, B, C
    i_cur_mag = {72'h0, 24'h20, 24'h30, 24'h10};
    i_volt_mag = 24'hABCDEF;
    i_cur_valid = 1;
    i_volt_valid = 1;
    tick;
    i_cur_valid = 0;
    i_volt_valid = 0;
    rd(16'hE500, 32'h02000030);
    rd(16'hE501, 32'h00ABCDEF);
    wr(16'hE500, 32'h0);
    rd(16'hE500, 32'h02000030);
    // Only A enabled after restart, so the smaller A wins
    i_peak_enable = 3'h1;
    i_peak_restart = 1;
    tick;
    i_peak_restart = 0;
    i_cur_valid = 1;
    tick;
    i_cur_valid = 0;
    rd(16'hE500, 32'h01000010);
    i_overcurrent_evt = 3'h4;
    tick;
    i_overcurrent_evt = 3'h0;
    rd(16'hE600, 32'h20);
    wr(16'hE600, 32'hFFFF);
    rd(16'hE600, 32'h20);
    i_overcurrent_clear = 1;
    tick;
    i_overcurrent_clear = 0;
    rd(16'hE600, 32'h0);
    i_noload = 6'h2A;
    tick;
    rd(16'hE608, 32'h2A);
    wrap_up;
  end
  // Watchdog: the tests need well under 2000 cycles
  initial begin
    #200000;
    mismatches = mismatches + 1;
    wrap_up;
  end
endmodule // testbench
